// File: core/stc_prescaler.sv
`timescale 1ns/1ps
module stc_prescaler
    import stc_pkg::*;
#(
    parameter int PRE_W = STC_PRE_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic src_tick,
    output logic [PRE_W-1:0] taps
);
    logic [PRE_W-1:0] cnt_ff;
    logic [PRE_W-1:0] nxt_cnt;

    // Stop clears the divider chain
    assign nxt_cnt = !run ? '0 : (src_tick ? cnt_ff + 1'b1 : cnt_ff); // RULE_08

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    // Tap i toggles every 2^i source ticks
    assign taps = cnt_ff;

endmodule : stc_prescaler

// File: core/stc_timer.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// RULE_01 - Counter is 16-bit binary up-counter
// RULE_02 - Readback read while running latches count
// RULE_03 - Readback register is read-only
// RULE_04 - Two compare registers, reset zero
// RULE_05 - Two read-only capture registers
// RULE_06 - Prescaler input is fperiph divided 1..32
// RULE_07 - Peripheral clock gear or high-speed
// RULE_08 - Prescaler run bit starts, clear stops; code also runs it while sync_en and master_start are both set
// RULE_09 - Count clock from taps or pin
// RULE_10 - Software run starts, stop clears counter
// RULE_11 - Trigger mode waits for pin edge
// RULE_12 - Edge select: 0 rising, 1 falling
// RULE_13 - Trigger mode stop clears counter
// RULE_14 - Slave follows master start and stop
// RULE_15 - Software keeps master sync bit zero
// RULE_16 - Sync mode beats trigger mode
// RULE_17 - Master-slave pairing fixed in hardware
// RULE_18 - Clear-on-match clears at compare 1
// RULE_19 - Overflow raises interrupt request
// RULE_20 - Double buffer loads on compare 1 match
// RULE_21 - Stopped readback keeps last sample
// RULE_22 - Counter wraps to zero at maximum
// RULE_23 - Read-only and reserved writes ignored
module stc_timer
    import stc_pkg::*;
#(
    parameter int CNT_W = STC_CNT_W,
    parameter int GEAR_DIV = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hs_clk_tick,
    input wire logic external_count_input,
    input wire logic master_start,
    output logic start_out,
    output logic timer_interrupt_request,
    output logic match0_pulse,
    output logic match1_pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers and wires
    logic cnt_run_ff, pre_run_ff, sync_ff, trigger_start_select_ff, edge_ff, dbuf_ff;
    logic clr_ff;
    logic [2:0] clk_sel_ff, pre_div_ff;
    logic fp_sel_ff;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [CNT_W-1:0] cmp0_ff, cmp1_ff, buf0_ff, buf1_ff;
    logic [CNT_W-1:0] cap0_ff, cap1_ff, live_ff;
    logic [2:0] sts_ff;
    logic [31:0] prdata_ff;
    stc_state_type state_ff, nxt_state;
    logic pin_s1_ff, pin_s2_ff, pin_d_ff;
    logic [7:0] gear_ff;
    logic [STC_PRE_W-1:0] taps, taps_d_ff;
    stc_cfg_type cfg;

    assign cfg = '{cnt_run: cnt_run_ff, pre_run: pre_run_ff, sync_en: sync_ff,
                   trig_sel: trigger_start_select_ff, trig_edge: edge_ff, dbuf_en: dbuf_ff,
                   clr_match: clr_ff, clk_sel: clk_sel_ff, pre_div: pre_div_ff,
                   fp_sel: fp_sel_ff};

    // Tap rising edge: one-cycle tick when tap bit goes 0 to 1
    function automatic logic tap_tick(input logic [STC_PRE_W-1:0] now,
                                      input logic [STC_PRE_W-1:0] was,
                                      input int idx);
        tap_tick = now[idx] && !was[idx];
    endfunction : tap_tick

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire wr_en = psel && penable && pwrite;
    wire rd_en = psel && penable && !pwrite;
    wire hit = (paddr == STC_OFF_RUN) || (paddr == STC_OFF_CTRL) ||
               (paddr == STC_OFF_MODE) || (paddr == STC_OFF_CLKGEN) ||
               (paddr == STC_OFF_LIVE) || (paddr == STC_OFF_CMP0) ||
               (paddr == STC_OFF_CMP1) || (paddr == STC_OFF_CAP0) ||
               (paddr == STC_OFF_CAP1) || (paddr == STC_OFF_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser; the second stage and its one-cycle delayed copy feed the edge logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_d_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= external_count_input;
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff <= pin_s2_ff;
        end
    end
    wire pin_rise = pin_s2_ff && !pin_d_ff;
    wire pin_fall = !pin_s2_ff && pin_d_ff;
    wire trig_edge_hit = cfg.trig_edge ? pin_fall : pin_rise; // RULE_12

    ////////////////////////////////////////////////////////////////////////////
    // Peripheral clock: gear divider tick or high-speed tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gear_ff <= 8'h00;
        else
            gear_ff <= (gear_ff == 8'(GEAR_DIV - 1)) ? 8'h00 : gear_ff + 8'h01;
    end
    wire gear_tick = (gear_ff == 8'h00);
    wire fperiph_tick = cfg.fp_sel ? hs_clk_tick : gear_tick; // RULE_07

    // Prescaler input fperiph/1..32 taken from the same chain
    logic [5:0] div_cnt_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt_ff <= 6'h00;
        else if (fperiph_tick)
            div_cnt_ff <= div_cnt_ff + 6'h01;
    end
    wire [5:0] div_mask = 6'((6'h01 << cfg.pre_div) - 6'h01);
    wire phi_t0 = fperiph_tick && ((div_cnt_ff & div_mask) == 6'h00); // RULE_06

    stc_prescaler #(.PRE_W(STC_PRE_W)) u_pre
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(cfg.pre_run || (cfg.sync_en && master_start)), // RULE_08
        .src_tick(phi_t0),
        .taps(taps)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            taps_d_ff <= '0;
        else
            taps_d_ff <= taps;
    end

    // Count clock select: pin, or T1,T4,T16,T32,T64,T128,T256
    logic cnt_tick;
    always_comb
    begin
        case (cfg.clk_sel) // RULE_09
            3'h0: cnt_tick = pin_rise;
            3'h1: cnt_tick = tap_tick(taps, taps_d_ff, 0);
            3'h2: cnt_tick = tap_tick(taps, taps_d_ff, 2);
            3'h3: cnt_tick = tap_tick(taps, taps_d_ff, 4);
            3'h4: cnt_tick = tap_tick(taps, taps_d_ff, 5);
            3'h5: cnt_tick = tap_tick(taps, taps_d_ff, 6);
            3'h6: cnt_tick = tap_tick(taps, taps_d_ff, 7);
            default: cnt_tick = tap_tick(taps, taps_d_ff, 8);
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start control; sync beats trigger, pairing is by wiring only
    wire run_req = cfg.sync_en ? master_start : cfg.cnt_run; // RULE_14 RULE_16 RULE_17
    wire use_trig = cfg.trig_sel && !cfg.sync_en; // RULE_16
    assign start_out = run_req && (state_ff == STC_RUN);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            STC_IDLE:
                if (run_req)
                    nxt_state = use_trig ? STC_WAIT : STC_RUN; // RULE_10 RULE_11
            STC_WAIT:
                if (!run_req)
                    nxt_state = STC_IDLE;
                else if (trig_edge_hit)
                    nxt_state = STC_RUN; // RULE_11
            STC_RUN:
                if (!run_req)
                    nxt_state = STC_IDLE; // RULE_10 RULE_13
            default: nxt_state = STC_IDLE;
        endcase
    end

    wire running = (state_ff == STC_RUN);
    wire m0 = running && (cnt_ff == cmp0_ff);
    wire m1 = running && (cnt_ff == cmp1_ff);
    wire ovf = running && cnt_tick && (cnt_ff == STC_CNT_MAX);
    assign match0_pulse = m0 && cnt_tick;
    assign match1_pulse = m1 && cnt_tick;

    // Counter: clear on stop or match, else wrap-around count
    always_comb
    begin
        if (!running || !run_req)
            nxt_cnt = STC_CNT_ZERO; // RULE_10 RULE_13
        else if (cnt_tick && cfg.clr_match && m1)
            nxt_cnt = STC_CNT_ZERO; // RULE_18
        else if (cnt_tick)
            nxt_cnt = cnt_ff + 1'b1; // RULE_01 RULE_22
        else
            nxt_cnt = cnt_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= STC_IDLE;
            cnt_ff <= STC_CNT_ZERO;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers; reserved bits never stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_run_ff <= 1'b0;
            pre_run_ff <= 1'b0;
            sync_ff <= 1'b0;
            trigger_start_select_ff <= 1'b0;
            edge_ff <= 1'b0;
            dbuf_ff <= 1'b0;
            clr_ff <= 1'b0;
            clk_sel_ff <= STC_CLK_EXT;
            pre_div_ff <= 3'h0;
            fp_sel_ff <= 1'b0;
        end
        else if (wr_en)
        begin
            case (paddr) // RULE_23
                STC_OFF_RUN:
                begin
                    cnt_run_ff <= pwdata[STC_RUN_CNT_BIT];
                    pre_run_ff <= pwdata[STC_RUN_PRE_BIT];
                end
                STC_OFF_CTRL:
                begin
                    sync_ff <= pwdata[STC_CTRL_SYNC_BIT];
                    trigger_start_select_ff <= pwdata[STC_CTRL_TRIGGER_START_SELECT_BIT];
                    edge_ff <= pwdata[STC_CTRL_EDGE_BIT];
                    dbuf_ff <= pwdata[STC_CTRL_DBUF_BIT];
                end
                STC_OFF_MODE:
                begin
                    clk_sel_ff <= pwdata[STC_MODE_CLK_LSB +: 3];
                    clr_ff <= pwdata[STC_MODE_CLE_BIT];
                end
                STC_OFF_CLKGEN:
                begin
                    pre_div_ff <= (pwdata[STC_CG_DIV_LSB +: 3] > 3'h5) ? 3'h5 :
                                  pwdata[STC_CG_DIV_LSB +: 3];
                    fp_sel_ff <= pwdata[STC_CG_PERIPHERAL_CLOCK_SOURCE_SELECT_BIT];
                end
                default: ;
            endcase
        end
    end

    // Compare registers with optional double buffer
    wire wr_cmp0 = wr_en && (paddr == STC_OFF_CMP0);
    wire wr_cmp1 = wr_en && (paddr == STC_OFF_CMP1);
    wire buffered = cfg.dbuf_en && running;
    wire load_buf = buffered && match1_pulse;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp0_ff <= '0;
            cmp1_ff <= '0;
            buf0_ff <= '0;
            buf1_ff <= '0;
        end
        else
        begin
            if (wr_cmp0) buf0_ff <= pwdata[CNT_W-1:0];
            if (wr_cmp1) buf1_ff <= pwdata[CNT_W-1:0];
            if (load_buf) // RULE_20
            begin
                cmp0_ff <= wr_cmp0 ? pwdata[CNT_W-1:0] : buf0_ff;
                cmp1_ff <= wr_cmp1 ? pwdata[CNT_W-1:0] : buf1_ff;
            end
            else if (!buffered) // RULE_04 RULE_20
            begin
                if (wr_cmp0) cmp0_ff <= pwdata[CNT_W-1:0];
                if (wr_cmp1) cmp1_ff <= pwdata[CNT_W-1:0];
            end
        end
    end

    // Capture: software capture to 0, compare-1 match to 1
    wire swcap = wr_en && (paddr == STC_OFF_MODE) && !pwdata[STC_MODE_SWCAP_BIT];
    // Latch in the setup cycle, so the word returned is the word kept
    wire rd_live = psel && !penable && !pwrite && (paddr == STC_OFF_LIVE);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cap0_ff <= '0;
            cap1_ff <= '0;
            live_ff <= '0;
            sts_ff <= 3'h0;
        end
        else
        begin
            if (swcap) cap0_ff <= cnt_ff; // RULE_05
            if (match1_pulse) cap1_ff <= cnt_ff; // RULE_05
            if (running && rd_live)
                live_ff <= cnt_ff; // RULE_02 RULE_21
            // Status: set wins over read clear
            sts_ff <= ((rd_en && paddr == STC_OFF_STATUS) ? 3'h0 : sts_ff) |
                      {ovf, match1_pulse, match0_pulse}; // RULE_19
        end
    end
    assign timer_interrupt_request = |sts_ff; // RULE_19

    ////////////////////////////////////////////////////////////////////////////
    // Read mux, registered at setup so data is valid in access phase
    logic [31:0] rd_mux;
    always_comb
    begin
        case (paddr)
            STC_OFF_RUN: rd_mux = 32'({cfg.pre_run, 1'b0, cfg.cnt_run});
            STC_OFF_CTRL: rd_mux = 32'({cfg.dbuf_en, cfg.trig_edge, cfg.trig_sel,
                                        cfg.sync_en, 5'h00});
            STC_OFF_MODE: rd_mux = 32'({1'b1, cfg.clr_match, cfg.clk_sel});
            STC_OFF_CLKGEN: rd_mux = 32'({cfg.fp_sel, 1'b0, cfg.pre_div});
            STC_OFF_LIVE: rd_mux = 32'(running ? cnt_ff : live_ff); // RULE_02 RULE_03
            STC_OFF_CMP0: rd_mux = 32'(cmp0_ff);
            STC_OFF_CMP1: rd_mux = 32'(cmp1_ff);
            STC_OFF_CAP0: rd_mux = 32'(cap0_ff);
            STC_OFF_CAP1: rd_mux = 32'(cap1_ff);
            STC_OFF_STATUS: rd_mux = 32'(sts_ff);
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h0000_0000;
        else if (psel && !penable)
            prdata_ff <= rd_mux;
    end
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_stop;
        running && !run_req;
    endsequence
    a_stop_clears: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
        s_stop |=> cnt_ff == STC_CNT_ZERO && state_ff == STC_IDLE)
        else $error("stop did not clear counter");
    a_trig_waits: assert property (@(posedge pclk) disable iff (!presetn) // RULE_11
        state_ff == STC_WAIT && run_req && !trig_edge_hit |=> state_ff == STC_WAIT)
        else $error("left trigger wait without edge");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        running && run_req && cnt_tick && !(cfg.clr_match && m1) |=>
        cnt_ff == 16'($past(cnt_ff) + 16'h0001))
        else $error("counter step wrong");
    a_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
        ovf && run_req |=> cnt_ff == STC_CNT_ZERO ##0 sts_ff[2])
        else $error("no wrap or overflow flag");
    a_clear_match: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
        match1_pulse && cfg.clr_match && run_req |=> cnt_ff == STC_CNT_ZERO)
        else $error("clear on match failed");
    a_sync_prio: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
        state_ff == STC_IDLE && cfg.sync_en && master_start |=> state_ff == STC_RUN)
        else $error("sync did not start at once");
    a_buf_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE_20
        load_buf && !wr_cmp1 |=> cmp1_ff == $past(buf1_ff))
        else $error("buffer not loaded");
    a_live_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE_21
        !running && $past(!running) |-> $stable(live_ff))
        else $error("readback changed while stopped");
    a_pre_stop: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        !cfg.pre_run && !cfg.sync_en |=> taps == '0)
        else $error("prescaler not cleared");

endmodule : stc_timer

// File: pkg/stc_pkg.sv
package stc_pkg;

    // Register byte offsets
    localparam logic [7:0] STC_OFF_RUN = 8'h00;
    localparam logic [7:0] STC_OFF_CTRL = 8'h04;
    localparam logic [7:0] STC_OFF_MODE = 8'h08;
    localparam logic [7:0] STC_OFF_CLKGEN = 8'h0c;
    localparam logic [7:0] STC_OFF_LIVE = 8'h10;
    localparam logic [7:0] STC_OFF_CMP0 = 8'h14;
    localparam logic [7:0] STC_OFF_CMP1 = 8'h18;
    localparam logic [7:0] STC_OFF_CAP0 = 8'h1c;
    localparam logic [7:0] STC_OFF_CAP1 = 8'h20;
    localparam logic [7:0] STC_OFF_STATUS = 8'h24;

    // Run register fields
    localparam int STC_RUN_CNT_BIT = 0;
    localparam int STC_RUN_PRE_BIT = 2;
    // Control register fields
    localparam int STC_CTRL_SYNC_BIT = 5;
    localparam int STC_CTRL_TRIGGER_START_SELECT_BIT = 6;
    localparam int STC_CTRL_EDGE_BIT = 7;
    localparam int STC_CTRL_DBUF_BIT = 8;
    // Mode register fields
    localparam int STC_MODE_CLK_LSB = 0;
    localparam int STC_MODE_CLE_BIT = 3;
    localparam int STC_MODE_SWCAP_BIT = 4;
    // Clock generator fields
    localparam int STC_CG_DIV_LSB = 0;
    localparam int STC_CG_PERIPHERAL_CLOCK_SOURCE_SELECT_BIT = 4;

    localparam int STC_CNT_W = 16;
    localparam int STC_PRE_W = 13;
    localparam logic [15:0] STC_CNT_ZERO = 16'h0000;
    localparam logic [15:0] STC_CNT_MAX = 16'hffff;
    localparam logic [2:0] STC_CLK_EXT = 3'h0;

    typedef enum logic [1:0]
    {
        STC_IDLE = 2'b00,
        STC_WAIT = 2'b01,
        STC_RUN = 2'b10
    } stc_state_type;

    typedef struct packed
    {
        logic cnt_run;
        logic pre_run;
        logic sync_en;
        logic trig_sel;
        logic trig_edge;
        logic dbuf_en;
        logic clr_match;
        logic [2:0] clk_sel;
        logic [2:0] pre_div;
        logic fp_sel;
    } stc_cfg_type;

endpackage : stc_pkg

// File: testbench/sixteen_bit_timer_core_bench.sv
`timescale 1ns/1ps
module sixteen_bit_timer_core_bench;
    import stc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic hs_clk_tick = 1'b0;
    logic external_count_input;
    logic master_start = 1'b0;
    logic start_out;
    logic timer_interrupt_request;
    logic match0_pulse;
    logic match1_pulse;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic [31:0] v;
    logic err;
    int n;
    int n1;
    int m0_seen = 0;
    int m1_seen = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and a random high-speed tick
    always #25 pclk = ~pclk;
    always @(posedge pclk) hs_clk_tick <= 1'($urandom_range(1, 0));

    // Count one-cycle match pulses as the design presents them at each edge
    always @(posedge pclk)
    begin
        if (match0_pulse === 1'b1)
            m0_seen <= m0_seen + 1;
        if (match1_pulse === 1'b1)
            m1_seen <= m1_seen + 1;
    end

    stc_timer u_dut
    (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .hs_clk_tick(hs_clk_tick),
        .external_count_input(external_count_input),
        .master_start(master_start),
        .start_out(start_out),
        .timer_interrupt_request(timer_interrupt_request),
        .match0_pulse(match0_pulse),
        .match1_pulse(match1_pulse)
    );

    stc_pin_model u_pin
    (
        .pclk(pclk),
        .external_count_input(external_count_input)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
    endtask : check

    // One APB transfer; the request is held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1)
        begin
            fail_count++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(name, q, exp);
    endtask : expect_reg

    // Readback image of a 16-bit field: upper half always zero
    function automatic logic [31:0] word16(input logic [31:0] x);
        return {16'h0000, x[15:0]};
    endfunction : word16

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog, so a stuck design still reaches the verdict
    initial
    begin
        #2000000;
        fail_count++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        void'($urandom(21997));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        expect_reg(STC_OFF_CMP0, 32'h0000_0000, "cmp0_reset");
        expect_reg(STC_OFF_CMP1, 32'h0000_0000, "cmp1_reset");
        expect_reg(STC_OFF_LIVE, 32'h0000_0000, "live_reset");
        apb(1'b0, 8'hfc, 32'h0000_0000, rd, err);
        check("unmapped_err", {31'h0, err}, 32'h0000_0001);
        check("unmapped_data", rd, 32'h0000_0000);
        // Random compare values, upper half written with random bits too
        for (int i = 0; i < 6; i++)
        begin
            v = $urandom();
            wr(STC_OFF_CMP0 + 8'(4 * (i % 2)), v);
            expect_reg(STC_OFF_CMP0 + 8'(4 * (i % 2)), word16(v), "cmp_rw");
        end
        wr(STC_OFF_LIVE, 32'hffff_ffff);
        expect_reg(STC_OFF_LIVE, 32'h0000_0000, "live_ro");
        // Event counting from the pin, random count and pulse widths
        wr(STC_OFF_MODE, 32'h0000_0010);
        wr(STC_OFF_RUN, 32'h0000_0005);
        n = $urandom_range(20, 1);
        u_pin.pulses(n, 1'b1);
        expect_reg(STC_OFF_LIVE, 32'(n), "live_count");
        wr(STC_OFF_MODE, 32'h0000_0000);
        expect_reg(STC_OFF_CAP0, 32'(n), "soft_capture");
        wr(STC_OFF_CAP0, 32'hffff_ffff);
        expect_reg(STC_OFF_CAP0, 32'(n), "cap0_ro");
        wr(STC_OFF_RUN, 32'h0000_0000);
        expect_reg(STC_OFF_LIVE, 32'(n), "live_hold");
        wr(STC_OFF_RUN, 32'h0000_0005);
        expect_reg(STC_OFF_LIVE, 32'h0000_0000, "stop_clears");
        // Clear on compare 1 at 5: seven fast pulses leave the count at 1
        wr(STC_OFF_MODE, 32'h0000_0018);
        wr(STC_OFF_CMP1, 32'h0000_0005);
        wr(STC_OFF_CMP0, 32'h0000_0003);
        apb(1'b0, STC_OFF_STATUS, 32'h0000_0000, rd, err);
        n = m0_seen;
        n1 = m1_seen;
        u_pin.pulses(7, 1'b0);
        check("match0_pulses", 32'(m0_seen - n), 32'h0000_0001);
        check("match1_pulses", 32'(m1_seen - n1), 32'h0000_0001);
        expect_reg(STC_OFF_LIVE, 32'h0000_0001, "clear_on_match");
        check("irq_set", {31'h0, timer_interrupt_request}, 32'h0000_0001);
        apb(1'b0, STC_OFF_STATUS, 32'h0000_0000, rd, err);
        check("match1_flag", {31'h0, rd[1]}, 32'h0000_0001);
        check("match0_flag", {31'h0, rd[0]}, 32'h0000_0001);
        @(negedge pclk);
        check("irq_cleared", {31'h0, timer_interrupt_request}, 32'h0000_0000);
        // Double buffer: a running write waits for the next compare 1 match
        wr(STC_OFF_CTRL, 32'h0000_0100);
        wr(STC_OFF_CMP1, 32'h0000_0002);
        expect_reg(STC_OFF_CMP1, 32'h0000_0005, "dbuf_hold");
        u_pin.pulses(5, 1'b0);
        expect_reg(STC_OFF_CMP1, 32'h0000_0002, "dbuf_load");
        expect_reg(STC_OFF_LIVE, 32'h0000_0000, "dbuf_clear");
        wr(STC_OFF_RUN, 32'h0000_0000);
        // Random clock generator setting, prescaler held stopped
        wr(STC_OFF_CLKGEN, 32'($urandom_range(5, 0)) | 32'($urandom_range(1, 0) << 4));
        wr(STC_OFF_MODE, 32'h0000_0011);
        wr(STC_OFF_RUN, 32'h0000_0001);
        repeat (300) @(posedge pclk);
        expect_reg(STC_OFF_LIVE, 32'h0000_0000, "prescaler_off");
        wr(STC_OFF_RUN, 32'h0000_0000);
        // Trigger start, both edges; the wrong edge comes first
        v = 32'h0000_0000;
        for (int e = 0; e < 2; e++)
        begin
            u_pin.drive(~1'(e));
            wr(STC_OFF_CTRL, 32'h0000_0040 | 32'(e << 7));
            wr(STC_OFF_RUN, 32'h0000_0005);
            u_pin.drive(1'(e));
            repeat (300) @(posedge pclk);
            expect_reg(STC_OFF_LIVE, v, "trig_wait");
            u_pin.drive(~1'(e));
            repeat (300) @(posedge pclk);
            apb(1'b0, STC_OFF_LIVE, 32'h0000_0000, rd, err);
            check("trig_started", {31'h0, rd != 32'h0}, 32'h0000_0001);
            v = rd; // Readback keeps this sample once stopped
            wr(STC_OFF_RUN, 32'h0000_0000);
        end
        // Slave start from the master, trigger select also set but no edge given
        wr(STC_OFF_CTRL, 32'h0000_0060);
        @(posedge pclk);
        master_start <= 1'b1;
        repeat (300) @(posedge pclk);
        apb(1'b0, STC_OFF_LIVE, 32'h0000_0000, rd, err);
        check("sync_start", {31'h0, rd != 32'h0}, 32'h0000_0001);
        check("start_out_on", {31'h0, start_out}, 32'h0000_0001);
        master_start <= 1'b0;
        repeat (20) @(posedge pclk);
        check("start_out_off", {31'h0, start_out}, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : sixteen_bit_timer_core_bench

// File: testbench/stc_pin_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of the timer: the external count and trigger pin
module stc_pin_model
(
    input wire logic pclk,
    output logic external_count_input
);
    // Pin idles low until a scenario moves it
    initial external_count_input = 1'b0;

    // Single level change, used to make one trigger edge
    task automatic drive(input logic level);
        @(posedge pclk);
        external_count_input <= level;
    endtask : drive

    // Count pulses; slow ones stretch both phases well past the synchroniser
    task automatic pulses(input int n, input bit slow);
        for (int i = 0; i < n; i++)
        begin
            @(posedge pclk);
            external_count_input <= 1'b1;
            repeat (slow ? $urandom_range(12, 4) : 3) @(posedge pclk);
            external_count_input <= 1'b0;
            repeat (slow ? $urandom_range(12, 4) : 3) @(posedge pclk);
        end
        // Let the last edge pass the two-flop synchroniser
        repeat (6) @(posedge pclk);
    endtask : pulses
endmodule : stc_pin_model
